// >>> rtl/wsl_top.sv
/*
  Watchdog timer with fuse-selected safety levels: avalon-mm register slave, control
  register with timed change window, oscillator tick divider, reset pulse and flag,
  interrupt status and mask.
  Assumes all inputs are synchronous to core_clk_i and fuse levels are stable after reset.
*/
`timescale 1ns/100ps
module wsl_top #(
  parameter int unsigned BASE_CYCLES = wsl_pkg::BASE_OSC_CYCLES,
  parameter int unsigned OSC_DIV     = wsl_pkg::OSC_DIV
) (
  input  wire logic        core_clk_i,             // 50 MHz core clock
  input  wire logic        rst_n_i,                // power-on reset, active low
  input  wire logic        chip_reset_i,           // other chip reset sources, active high
  input  wire logic        restart_instruction_i,  // restart instruction pulse
  input  wire logic        always_on_fuse_i,       // 1 = programmed
  input  wire logic        compatibility_fuse_i,   // 1 = programmed
  input  wire logic [4:0]  avs_address_i,          // byte address
  input  wire logic        avs_read_i,             // read request
  input  wire logic        avs_write_i,            // write request
  input  wire logic [3:0]  avs_byteenable_i,       // byte lanes
  input  wire logic [31:0] avs_writedata_i,        // write data
  output logic [31:0]      avs_readdata_o,         // read data
  output logic             avs_waitrequest_o,      // stall
  output logic             chip_reset_o,           // timeout reset pulse
  output logic             timeout_reset_flag_o,   // sticky timeout flag
  output logic             watchdog_enabled_o,     // effective enable
  output logic             irq_o                   // level interrupt
);

  localparam int unsigned DIV_W = wsl_pkg::DIV_W;

  wsl_pkg::wsl_state_s   s_q;
  wsl_pkg::wsl_state_s   s_d;
  wsl_pkg::wsl_avs_req_s req;
  logic [1:0]            rst_sync_q;
  logic                  rst_n;
  logic                  timeout;
  logic                  en_eff;
  logic                  cnt_clear;

  // two-stage reset release; only stage two feeds the design
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  assign req = '{address:    avs_address_i,
                 read:       avs_read_i,
                 write:      avs_write_i,
                 byteenable: avs_byteenable_i,
                 writedata:  avs_writedata_i};

  // level 2 forces the watchdog on whatever was written
  assign en_eff    = s_q.ctrl.watchdog_enable_bit || (s_q.level == wsl_pkg::WSL_LEVEL2);
  assign cnt_clear = s_q.restart || chip_reset_i || s_q.reset_pulse;

  // read multiplexer, reserved and unmapped bits read zero
  function automatic logic [7:0] read_mux(input wsl_pkg::wsl_state_s s, input logic [4:0] a, input logic en);
    wsl_pkg::wsl_ctrl_s c;
    c          = s.ctrl;
    c.reserved = 3'h0;
    c.watchdog_enable_bit = en;
    read_mux   = 8'h00;
    unique case (a)
      wsl_pkg::OFS_CONTROL:    read_mux = c;
      wsl_pkg::OFS_RST_STATUS: read_mux = 8'(s.flag) << wsl_pkg::FLAG_BIT;
      wsl_pkg::OFS_IRQ_STATUS: read_mux = {6'h00, s.irq_sts};
      wsl_pkg::OFS_IRQ_MASK:   read_mux = {6'h00, s.irq_mask};
      default:                 read_mux = 8'h00;
    endcase
  endfunction

  always_comb begin
    logic               wr_go;
    logic               rd_go;
    logic               ce_open;
    logic [1:0]         ev;
    wsl_pkg::wsl_ctrl_s w;
    s_d      = s_q;
    ev       = 2'h0;
    ce_open  = s_q.ctrl.change_enable_bit;
    w        = wsl_pkg::wsl_ctrl_s'(req.writedata[7:0]);
    wr_go    = req.write && !s_q.waitreq && req.byteenable[0];
    rd_go    = req.read && !s_q.waitreq;

    // fuse straps caught once after reset release
    if (!s_q.fuse_done) begin
      s_d.fuse_done = 1'b1;
      if (always_on_fuse_i) begin
        s_d.level = wsl_pkg::WSL_LEVEL2;
        s_d.ctrl.watchdog_enable_bit = 1'b1;
      end else if (compatibility_fuse_i) begin
        s_d.level = wsl_pkg::WSL_LEVEL0;
      end else begin
        s_d.level = wsl_pkg::WSL_LEVEL1;
      end
    end

    // oscillator tick divider, one enable pulse per 1 us
    s_d.tick = 1'b0;
    if (s_q.div == DIV_W'(OSC_DIV - 1)) begin
      s_d.div  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.div = s_q.div + 1'b1;
    end

    // change window closes by itself
    if (s_q.ce_cnt != 3'h0) begin
      s_d.ce_cnt = s_q.ce_cnt - 1'b1;
      if (s_q.ce_cnt == 3'h1) begin
        s_d.ctrl.change_enable_bit = 1'b0;
      end
    end

    // avalon handshake: stall one cycle, answer in the next
    s_d.waitreq = 1'b1;
    if ((req.read || req.write) && s_q.waitreq) begin
      s_d.waitreq = 1'b0;
      s_d.rdata   = read_mux(s_q, req.address, en_eff);
    end

    // restart registered so it reaches the counter one cycle later
    s_d.restart = restart_instruction_i;
    if (wr_go && req.address == wsl_pkg::OFS_RESTART) begin
      s_d.restart = 1'b1;
    end

    if (wr_go && req.address == wsl_pkg::OFS_CONTROL) begin
      if (w.watchdog_enable_bit) begin
        s_d.ctrl.watchdog_enable_bit = 1'b1;
      end else if (ce_open && s_q.level != wsl_pkg::WSL_LEVEL2) begin
        s_d.ctrl.watchdog_enable_bit = 1'b0;
      end else if (en_eff) begin
        ev[wsl_pkg::IRQ_REFUSED] = 1'b1;
      end
      if (s_q.level == wsl_pkg::WSL_LEVEL0 || ce_open) begin
        s_d.ctrl.prescale_select = w.prescale_select;
      end else if (w.prescale_select != s_q.ctrl.prescale_select) begin
        ev[wsl_pkg::IRQ_REFUSED] = 1'b1;
      end
      if (w.change_enable_bit) begin
        s_d.ctrl.change_enable_bit = 1'b1;
        s_d.ce_cnt                 = wsl_pkg::CE_HOLD_CYCLES;
      end
    end

    if (wr_go && req.address == wsl_pkg::OFS_IRQ_MASK) begin
      s_d.irq_mask = req.writedata[1:0];
    end

    // timeout: one-cycle reset pulse and sticky flag
    s_d.reset_pulse = timeout;
    ev[wsl_pkg::IRQ_TIMEOUT] = ev[wsl_pkg::IRQ_TIMEOUT] | timeout;
    if (wr_go && req.address == wsl_pkg::OFS_RST_STATUS && !req.writedata[wsl_pkg::FLAG_BIT]) begin
      s_d.flag = 1'b0;
    end
    if (timeout) begin
      s_d.flag = 1'b1;
    end

    // read clears only what was returned; new events win
    if (rd_go && req.address == wsl_pkg::OFS_IRQ_STATUS) begin
      s_d.irq_sts = s_q.irq_sts & ~s_q.rdata[1:0];
    end
    s_d.irq_sts = s_d.irq_sts | ev;
    s_d.irq     = |(s_d.irq_sts & s_d.irq_mask);
  end

  // one register stage for all state except the reset synchroniser
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_q.fuse_done   <= 1'b0;
      s_q.level       <= wsl_pkg::WSL_LEVEL1;
      s_q.ctrl        <= wsl_pkg::CTRL_RESET;
      s_q.ce_cnt      <= 3'h0;
      s_q.div         <= '0;
      s_q.tick        <= 1'b0;
      s_q.restart     <= 1'b0;
      s_q.waitreq     <= 1'b1;
      s_q.rdata       <= 8'h00;
      s_q.reset_pulse <= 1'b0;
      s_q.flag        <= 1'b0;
      s_q.irq_sts     <= 2'h0;
      s_q.irq_mask    <= 2'h0;
      s_q.irq         <= 1'b0;
    end else begin
      s_q.fuse_done   <= s_d.fuse_done;
      s_q.level       <= s_d.level;
      s_q.ctrl        <= s_d.ctrl;
      s_q.ce_cnt      <= s_d.ce_cnt;
      s_q.div         <= s_d.div;
      s_q.tick        <= s_d.tick;
      s_q.restart     <= s_d.restart;
      s_q.waitreq     <= s_d.waitreq;
      s_q.rdata       <= s_d.rdata;
      s_q.reset_pulse <= s_d.reset_pulse;
      s_q.flag        <= s_d.flag;
      s_q.irq_sts     <= s_d.irq_sts;
      s_q.irq_mask    <= s_d.irq_mask;
      s_q.irq         <= s_d.irq;
    end
  end

  // counter sees registered controls, except chip_reset_i which reaches clear_i unregistered
  wsl_counter #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_counter (
    .clk_i      (core_clk_i),
    .rst_n_i    (rst_n),
    .tick_i     (s_q.tick),
    .run_i      (en_eff && s_q.fuse_done),
    .clear_i    (cnt_clear),
    .prescale_i (s_q.ctrl.prescale_select),
    .timeout_o  (timeout)
  );

  // outputs straight from state flip-flops
  assign avs_readdata_o       = {24'h000000, s_q.rdata};
  assign avs_waitrequest_o    = s_q.waitreq;
  assign chip_reset_o         = s_q.reset_pulse;
  assign timeout_reset_flag_o = s_q.flag;
  assign watchdog_enabled_o   = s_q.ctrl.watchdog_enable_bit;
  assign irq_o                = s_q.irq;

endmodule

// >>> rtl/wsl_pkg.sv
/*
  Shared constants and types of the watchdog timer with fuse-selected safety levels:
  register offsets, field layouts, reset values, timing counts and the state carriers.
  Assumes a 50 MHz core clock; the watchdog oscillator rate is emulated by an enable divider.
*/
// Summary of operation
// - counter runs on its own 1 MHz tick
// - restart instruction clears the counter
// - counter cleared on disable and chip reset
// - period elapsed without restart issues chip reset
// - two fuses pick safety level and start state
// - enable write accepted at every level, untimed
// - control bits 7..5 always read zero
// - change-enable self-clears four cycles after set
// - enable clear only honoured while change-enable set
// - level 2 stays enabled, enable reads one
// - prescale select: 16384 cycles doubled per step
// - level 0 prescale writes always accepted
// - levels 1/2 prescale writes need change-enable
// - level 2 second write enable value ignored
// - timeout reset pulse lasts one core cycle
// - timeout sets flag; por or zero write clears
package wsl_pkg;

  // clock rates and derived tick divider
  localparam int unsigned CORE_HZ         = 50_000_000;
  localparam int unsigned OSC_HZ          = 1_000_000;
  localparam int unsigned OSC_DIV         = CORE_HZ / OSC_HZ;
  localparam int unsigned DIV_W           = 6;
  localparam int unsigned BASE_OSC_CYCLES = 16_384;
  localparam int unsigned CNT_W           = 22;
  localparam logic [2:0]  CE_HOLD_CYCLES  = 3'h4;

  // register byte offsets
  localparam logic [4:0] OFS_CONTROL    = 5'h00;
  localparam logic [4:0] OFS_RESTART    = 5'h04;
  localparam logic [4:0] OFS_RST_STATUS = 5'h08;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h0c;
  localparam logic [4:0] OFS_IRQ_MASK   = 5'h10;

  // field positions
  localparam int unsigned FLAG_BIT    = 3;
  localparam int unsigned IRQ_TIMEOUT = 0;
  localparam int unsigned IRQ_REFUSED = 1;

  typedef enum logic [1:0] {
    WSL_LEVEL0,
    WSL_LEVEL1,
    WSL_LEVEL2
  } wsl_level_e;

  typedef struct packed {
    logic [2:0] reserved;
    logic       change_enable_bit;
    logic       watchdog_enable_bit;
    logic [2:0] prescale_select;
  } wsl_ctrl_s;

  localparam wsl_ctrl_s CTRL_RESET = 8'h00;

  // avalon slave side request bundle
  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } wsl_avs_req_s;

  // state of the top module, except the reset synchroniser
  typedef struct packed {
    logic             fuse_done;
    wsl_level_e       level;
    wsl_ctrl_s        ctrl;
    logic [2:0]       ce_cnt;
    logic [DIV_W-1:0] div;
    logic             tick;
    logic             restart;
    logic             waitreq;
    logic [7:0]       rdata;
    logic             reset_pulse;
    logic             flag;
    logic [1:0]       irq_sts;
    logic [1:0]       irq_mask;
    logic             irq;
  } wsl_state_s;

  // state of the timeout counter
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             timeout;
  } wsl_cnt_s;

endpackage

// >>> rtl/wsl_counter.sv
/*
  Timeout counter of the watchdog, advanced by the oscillator tick enable.
  Assumes clear_i and run_i are synchronous to the core clock domain of the caller.
*/
`timescale 1ns/100ps
module wsl_counter #(
  parameter int unsigned BASE_CYCLES = wsl_pkg::BASE_OSC_CYCLES
) (
  input  wire logic       clk_i,       // core clock
  input  wire logic       rst_n_i,     // synchronised reset, active low
  input  wire logic       tick_i,      // one oscillator cycle
  input  wire logic       run_i,       // watchdog enabled
  input  wire logic       clear_i,     // restart or chip reset
  input  wire logic [2:0] prescale_i,  // prescale select
  output logic            timeout_o    // one-cycle expiry pulse
);

  wsl_pkg::wsl_cnt_s s_q;
  wsl_pkg::wsl_cnt_s s_d;

  // period in oscillator cycles, doubled per step
  function automatic logic [wsl_pkg::CNT_W-1:0] period(input logic [2:0] sel);
    logic [wsl_pkg::CNT_W-1:0] base;
    base   = wsl_pkg::CNT_W'(BASE_CYCLES);
    period = base << sel;
  endfunction

  // a shrunk period takes effect at once via >= compare
  always_comb begin
    s_d         = s_q;
    s_d.timeout = 1'b0;
    if (clear_i || !run_i) begin
      s_d.cnt = '0;
    end else if (tick_i) begin
      if (s_q.cnt >= period(prescale_i) - 1'b1) begin
        s_d.cnt     = '0;
        s_d.timeout = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign timeout_o = s_q.timeout;

endmodule

// >>> bench/wsl_sva.sv
/*
  port checker of the watchdog top module.
  assumes fuses change only while rst_n_i is low.
*/
`timescale 1ns/100ps
module wsl_sva #(
  parameter int unsigned BASE_CYCLES = wsl_pkg::BASE_OSC_CYCLES,
  parameter int unsigned OSC_DIV     = wsl_pkg::OSC_DIV
) (
  input wire logic        core_clk_i,            // core clock
  input wire logic        rst_n_i,               // reset, active low
  input wire logic        chip_reset_i,          // other reset sources
  input wire logic        restart_instruction_i, // restart pulse
  input wire logic        always_on_fuse_i,      // 1 = programmed
  input wire logic [4:0]  avs_address_i,         // byte address
  input wire logic        avs_read_i,            // read request
  input wire logic        avs_write_i,           // write request
  input wire logic [31:0] avs_readdata_o,        // read data
  input wire logic        avs_waitrequest_o,     // stall
  input wire logic        chip_reset_o,          // timeout pulse
  input wire logic        timeout_reset_flag_o,  // sticky flag
  input wire logic        watchdog_enabled_o     // effective enable
);
  localparam int unsigned MIN_GAP = (BASE_CYCLES - 2) * OSC_DIV;
  logic [2:0]  age_q;
  logic [23:0] gap_q;
  logic        dirty_q;
  logic        rd_ctl;
  logic        lvl2;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // control read answer and settled level 2
  assign rd_ctl = !avs_waitrequest_o && avs_read_i && avs_address_i == wsl_pkg::OFS_CONTROL;
  assign lvl2   = age_q == 3'h7 && always_on_fuse_i;

  // age since reset; gaps with writes in them are not judged, a write may move the period
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      age_q   <= 3'h0;
      gap_q   <= 24'h0;
      dirty_q <= 1'b1;
    end else begin
      if (age_q != 3'h7) age_q <= age_q + 3'h1;
      if (chip_reset_o || restart_instruction_i || chip_reset_i || !watchdog_enabled_o) begin
        gap_q   <= 24'h0;
        dirty_q <= avs_write_i;
      end else begin
        if (gap_q != 24'hffffff) gap_q <= gap_q + 24'h1;
        if (avs_write_i) dirty_q <= 1'b1;
      end
    end
  end

  sequence quiet_s;
    (!chip_reset_o) [*8];
  endsequence

  pulse_single_a: assert property (chip_reset_o |=> !chip_reset_o)
    else $error("timeout pulse longer than one cycle");
  flag_set_a: assert property (chip_reset_o |-> timeout_reset_flag_o)
    else $error("flag not set with timeout pulse");
  flag_sticky_a: assert property (timeout_reset_flag_o && !(avs_write_i && avs_address_i == wsl_pkg::OFS_RST_STATUS)
    |=> timeout_reset_flag_o) else $error("flag lost without clearing write");
  reserved_zero_a: assert property (rd_ctl |-> avs_readdata_o[7:5] == 3'h0)
    else $error("reserved control bits read nonzero");
  lvl2_on_a: assert property (lvl2 |-> watchdog_enabled_o)
    else $error("watchdog off at level 2");
  lvl2_read_a: assert property (rd_ctl && lvl2 |-> avs_readdata_o[3])
    else $error("enable bit reads zero at level 2");
  restart_quiet_a: assert property (restart_instruction_i |-> ##4 quiet_s)
    else $error("timeout soon after restart");
  chipreset_quiet_a: assert property (chip_reset_i |-> ##4 quiet_s)
    else $error("timeout soon after chip reset");
  disabled_quiet_a: assert property ((!watchdog_enabled_o) [*3] |-> !chip_reset_o)
    else $error("timeout while disabled");
  min_period_a: assert property (chip_reset_o && !dirty_q |-> gap_q >= MIN_GAP)
    else $error("timeout period too short");
endmodule

bind wsl_top wsl_sva #(.BASE_CYCLES(BASE_CYCLES), .OSC_DIV(OSC_DIV)) chk_u (.*);

// >>> bench/tb.sv
/*
  self-checking bench of the watchdog top module over all three safety levels.
  assumes the checker is bound from its own file.
*/
`timescale 1ns/100ps
module tb;
  localparam int unsigned B = 16;
  localparam int unsigned D = 2;
  localparam logic [4:0]  CT = wsl_pkg::OFS_CONTROL;
  logic        core_clk_i, rst_n_i, chip_reset_i, restart_instruction_i;
  logic        always_on_fuse_i, compatibility_fuse_i, avs_read_i, avs_write_i;
  logic [4:0]  avs_address_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, seed;
  logic        avs_waitrequest_o, chip_reset_o, timeout_reset_flag_o, watchdog_enabled_o, irq_o;
  logic [7:0]  q;
  int          fail_count, n_tests, pc, n;

  wsl_top #(.BASE_CYCLES(B), .OSC_DIV(D)) dut_u (.*);

  // 50 MHz core clock
  always #10 core_clk_i = ~core_clk_i;

  task automatic report_and_stop();
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic fail_now();
    $display("mismatch at %0t: wait timed out", $time);
    fail_count++;
    report_and_stop();
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chb(input logic g, input logic e);
    chk({7'h0, g}, {7'h0, e});
  endtask

  // advance edges, counting timeout pulses seen
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge core_clk_i);
      if (chip_reset_o === 1'b1) pc++;
    end
  endtask

  // one transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int i;
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= w;
    avs_read_i <= !w;
    i = 0;
    do begin
      @(posedge core_clk_i);
      i++;
    end while (avs_waitrequest_o !== 1'b0 && i < 20);
    q = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (i >= 20) fail_now();
  endtask

  task automatic wait_pulse(input int lim);
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (chip_reset_o !== 1'b1 && n < lim);
    if (n >= lim) fail_now();
  endtask

  // fuses only move while reset is held
  task automatic boot(input logic ao, input logic cf);
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    always_on_fuse_i <= ao;
    compatibility_fuse_i <= cf;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
  endtask

  function automatic int per(input logic [2:0] p);
    return (B << p) * D;
  endfunction

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  initial begin
    {core_clk_i, rst_n_i, chip_reset_i, restart_instruction_i} = 4'h0;
    {always_on_fuse_i, compatibility_fuse_i, avs_read_i, avs_write_i} = 4'h0;
    avs_address_i = 5'h00;
    avs_byteenable_i = 4'hf;
    avs_writedata_i = 32'h0;
    {fail_count, n_tests, pc} = 0;
    seed = 32'h0cc0;
    // level 1: window rules
    boot(1'b0, 1'b0);
    chb(watchdog_enabled_o, 1'b0);
    bus(0, CT, 8'h00); chk(q, 8'h00);
    bus(1, CT, 8'hff); bus(0, CT, 8'h00); chk(q, 8'h18);
    tick(6); bus(0, CT, 8'h00); chk(q, 8'h08);
    bus(1, CT, 8'h00); bus(0, CT, 8'h00); chk(q, 8'h08);
    bus(0, wsl_pkg::OFS_IRQ_STATUS, 8'h00); chk(q & 8'h02, 8'h02);
    bus(1, CT, 8'h18); bus(1, CT, 8'h0b); bus(0, CT, 8'h00); chk(q & 8'hef, 8'h0b);
    bus(1, CT, 8'h18); tick(6); bus(1, CT, 8'h0c); bus(0, CT, 8'h00); chk(q & 8'hef, 8'h0b);
    bus(1, CT, 8'h18); bus(1, CT, 8'h00); tick(1); chb(watchdog_enabled_o, 1'b0);
    pc = 0; tick(100); chk(pc[7:0], 8'h00);
    // level 0: every period code, pulse to pulse
    boot(1'b0, 1'b1);
    for (int p = 0; p < 8; p++) begin
      bus(1, CT, {5'h01, p[2:0]});
      wait_pulse(per(p) * 2 + 50);
      wait_pulse(per(p) * 2 + 50);
      chb(n >= per(p) - D && n <= per(p) + D, 1'b1);
    end
    chb(timeout_reset_flag_o, 1'b1);
    bus(1, wsl_pkg::OFS_RST_STATUS, 8'h00); bus(0, wsl_pkg::OFS_RST_STATUS, 8'h00); chk(q, 8'h00);
    chb(irq_o, 1'b0);
    bus(1, wsl_pkg::OFS_IRQ_MASK, 8'h01); tick(2); chb(irq_o, 1'b1);
    bus(0, wsl_pkg::OFS_IRQ_STATUS, 8'h00); chk(q, 8'h01); tick(2); chb(irq_o, 1'b0);
    repeat (8) begin
      seed = lfsr(seed);
      bus(1, CT, {5'h01, seed[2:0]}); bus(0, CT, 8'h00); chk(q, {5'h01, seed[2:0]});
    end
    bus(0, 5'h1c, 8'h00); chk(q, 8'h00);
    // restarts spaced below one period keep it quiet
    bus(1, CT, 8'h08);
    restart_instruction_i <= 1'b1; tick(1); restart_instruction_i <= 1'b0; tick(4); pc = 0;
    repeat (20) begin
      seed = lfsr(seed);
      restart_instruction_i <= 1'b1; tick(1); restart_instruction_i <= 1'b0; tick(2 + seed[3:0]);
    end
    bus(1, wsl_pkg::OFS_RESTART, 8'h01); tick(20); chk(pc[7:0], 8'h00);
    chip_reset_i <= 1'b1; tick(80); chk(pc[7:0], 8'h00);
    chip_reset_i <= 1'b0; wait_pulse(per(0) * 2 + 50); chb(n >= per(0) - D, 1'b1);
    // level 2: always on, period still changeable
    boot(1'b1, 1'b0);
    chb(watchdog_enabled_o, 1'b1);
    bus(0, CT, 8'h00); chk(q, 8'h08);
    bus(1, CT, 8'h18); bus(1, CT, 8'h02); bus(0, CT, 8'h00); chk(q & 8'hef, 8'h0a);
    bus(1, CT, 8'h18); bus(1, CT, 8'h00); tick(1); chb(watchdog_enabled_o, 1'b1);
    bus(0, CT, 8'h00); chk(q & 8'hef, 8'h08);
    report_and_stop();
  end
endmodule
